// *** bstap_pkg.sv ***
/*
 * Package for the boundary-scan test access port: TAP states, instruction
 * codes, identification layout and pin synchroniser depth.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package bstap_pkg;

    typedef enum logic [3:0] {
        ST_RESET,
        ST_IDLE,
        ST_SEL_DR,
        ST_CAP_DR,
        ST_SHIFT_DR,
        ST_EXIT1_DR,
        ST_PAUSE_DR,
        ST_EXIT2_DR,
        ST_UPD_DR,
        ST_SEL_IR,
        ST_CAP_IR,
        ST_SHIFT_IR,
        ST_EXIT1_IR,
        ST_PAUSE_IR,
        ST_EXIT2_IR,
        ST_UPD_IR
    } bstap_state_t;

    localparam int IR_W = 4;
    localparam logic [3:0] INS_EXTEST = 4'h0;
    localparam logic [3:0] INS_IDCODE = 4'h1;
    localparam logic [3:0] INS_SAMPLE = 4'h2;
    localparam logic [3:0] INS_FLOAT = 4'h3;
    localparam logic [3:0] INS_FIXED = 4'h4;
    localparam logic [3:0] INS_BYPASS = 4'hF;
    // value loaded into the instruction shifter at capture
    localparam logic [3:0] IR_CAPTURE = 4'h1;

    localparam int ID_W = 32;
    localparam int ID_VER_LSB = 28;
    localparam int ID_PART_LSB = 12;
    localparam int ID_MFR_LSB = 1;
    localparam logic ID_BIT0 = 1'b1;

    localparam int SYNC_STAGES = 2;

endpackage : bstap_pkg

// *** bstap_cell.sv ***
/*
 * One boundary cell: serial shift flip-flop and parallel output stage.
 * Assumes capture, shift and update strobes come from the TAP on clk.
 */
`timescale 1ns/10ps
`default_nettype none

module bstap_cell
(
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // scan control
    input wire logic capture,
    input wire logic shift,
    input wire logic update,
    input wire logic test_mode,
    // data
    input wire logic scan_in,
    input wire logic sys_in,
    output logic scan_out,
    output logic cell_out
);

    logic upd_q;

    // serial shift stage: capture or shift
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            scan_out <= 1'b0;
        else if (capture)
            scan_out <= sys_in;
        else if (shift)
            scan_out <= scan_in;
    end

    // parallel output stage moves only at update, acting as the latch
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            upd_q <= 1'b0;
        else if (update)
            upd_q <= scan_out;
    end

    // system function passes straight through outside test mode
    always_comb
    begin
        cell_out = test_mode ? upd_q : sys_in;
    end

endmodule : bstap_cell
`default_nettype wire

// *** bstap_top.sv ***
/*
 * Boundary-scan test access port: 16-state TAP, 4-bit instruction decode,
 * identification, bypass and boundary cell chain.
 * Assumes tck, tms and tdi arrive from a board tester, asynchronous to clk,
 * and that clk is much faster than tck so every tck edge is seen.
 */
// Functional notes
// - four pins: tck, tms, tdi in; tdo out
// - standard sixteen-state TAP steered by tms
// - power-on and device reset force test-logic-reset
// - reset selects identification instruction 0001
// - extest, sample and bypass instructions decoded
// - 0011 floats outputs, 0100 drives chain; bypass
// - 32-bit identification: version and part fields
// - manufacturer code in 11..1, bit0 one
// - cells: shift flop then parallel output stage
// - cells capture, shift, update, pass through
// - chain covers every device pin
// - test port keeps running during sleep
`timescale 1ns/10ps
`default_nettype none

module bstap_top
    import bstap_pkg::*;
#(
    parameter int NPINS = 8,
    parameter logic [3:0] ID_VERSION = 4'h0,   // arbitrary value
    parameter logic [15:0] ID_PART = 16'h0A5A, // arbitrary value
    parameter logic [10:0] ID_MFR = 11'h07E    // arbitrary value
)
(
    // clock and resets
    input wire logic clk,
    input wire logic rst,
    input wire logic por,
    // test port pins
    input wire logic tck,
    input wire logic tms,
    input wire logic tdi,
    output logic tdo,
    output logic tdo_oe,
    // device pins through the boundary chain
    input wire logic [NPINS-1:0] sys_out,
    input wire logic [NPINS-1:0] sys_oe,
    output logic [NPINS-1:0] pin_out,
    output logic [NPINS-1:0] pin_oe,
    input wire logic [NPINS-1:0] pin_in,
    output logic [NPINS-1:0] core_in,
    // sleep state, informational only
    input wire logic sleep
);

    // elaboration-time refusal of an empty chain
    if (NPINS < 1)
    begin : g_bad_npins
        $error("NPINS must be at least one");
    end

    logic [SYNC_STAGES-1:0] tck_s;
    logic [SYNC_STAGES-1:0] tms_s;
    logic [SYNC_STAGES-1:0] tdi_s;
    logic tck_d;
    logic rise;
    logic fall;
    logic rst_any;
    bstap_state_t state;
    bstap_state_t next_state;
    logic [IR_W-1:0] ir;
    logic [IR_W-1:0] ir_sh;
    logic [ID_W-1:0] id_sh;
    logic byp;
    logic sel_chain;
    logic sel_byp;
    logic test_mode;
    logic float_all;
    logic cap_dr;
    logic sh_dr;
    logic upd_dr;
    logic dr_out;
    logic tdo_next;
    // chain has 2*NPINS cells: pin output cells, then pin input cells
    logic [2*NPINS:0] chain;
    logic [2*NPINS-1:0] cell_par;
    logic [2*NPINS-1:0] cell_sys;
    logic [NPINS-1:0] oe_upd;

    // sleep does not gate anything here: the port stays live
    assign rst_any = rst | por;

    always_ff @(posedge clk or posedge rst_any)
    begin
        if (rst_any)
        begin
            tck_s <= '0;
            tms_s <= '0;
            tdi_s <= '0;
            tck_d <= 1'b0;
        end
        else
        begin
            tck_s <= {tck_s[0], tck};
            tms_s <= {tms_s[0], tms};
            tdi_s <= {tdi_s[0], tdi};
            tck_d <= tck_s[1];
        end
    end

    assign rise = tck_s[1] & ~tck_d;
    assign fall = ~tck_s[1] & tck_d;

    always_comb
    begin
        next_state = state;
        case (state)
            ST_RESET: next_state = tms_s[1] ? ST_RESET : ST_IDLE;
            ST_IDLE: next_state = tms_s[1] ? ST_SEL_DR : ST_IDLE;
            ST_SEL_DR: next_state = tms_s[1] ? ST_SEL_IR : ST_CAP_DR;
            ST_CAP_DR: next_state = tms_s[1] ? ST_EXIT1_DR : ST_SHIFT_DR;
            ST_SHIFT_DR: next_state = tms_s[1] ? ST_EXIT1_DR : ST_SHIFT_DR;
            ST_EXIT1_DR: next_state = tms_s[1] ? ST_UPD_DR : ST_PAUSE_DR;
            ST_PAUSE_DR: next_state = tms_s[1] ? ST_EXIT2_DR : ST_PAUSE_DR;
            ST_EXIT2_DR: next_state = tms_s[1] ? ST_UPD_DR : ST_SHIFT_DR;
            ST_UPD_DR: next_state = tms_s[1] ? ST_SEL_DR : ST_IDLE;
            ST_SEL_IR: next_state = tms_s[1] ? ST_RESET : ST_CAP_IR;
            ST_CAP_IR: next_state = tms_s[1] ? ST_EXIT1_IR : ST_SHIFT_IR;
            ST_SHIFT_IR: next_state = tms_s[1] ? ST_EXIT1_IR : ST_SHIFT_IR;
            ST_EXIT1_IR: next_state = tms_s[1] ? ST_UPD_IR : ST_PAUSE_IR;
            ST_PAUSE_IR: next_state = tms_s[1] ? ST_EXIT2_IR : ST_PAUSE_IR;
            ST_EXIT2_IR: next_state = tms_s[1] ? ST_UPD_IR : ST_SHIFT_IR;
            ST_UPD_IR: next_state = tms_s[1] ? ST_SEL_DR : ST_IDLE;
            default: next_state = ST_RESET;
        endcase
    end

    always_ff @(posedge clk or posedge rst_any)
    begin
        if (rst_any)
            state <= ST_RESET;
        else if (rise)
            state <= next_state;
    end

    // instruction shifter and instruction register
    always_ff @(posedge clk or posedge rst_any)
    begin
        if (rst_any)
        begin
            ir_sh <= IR_CAPTURE;
            ir <= INS_IDCODE;
        end
        else if (rise)
        begin
            case (state)
                ST_RESET: ir <= INS_IDCODE;
                ST_CAP_IR: ir_sh <= IR_CAPTURE;
                ST_SHIFT_IR: ir_sh <= {tdi_s[1], ir_sh[IR_W-1:1]};
                ST_UPD_IR: ir <= ir_sh;
                default: ir <= ir;
            endcase
        end
    end

    // decode; reserved codes fall back to bypass
    always_comb
    begin
        sel_chain = 1'b0;
        sel_byp = 1'b0;
        test_mode = 1'b0;
        float_all = 1'b0;
        case (ir)
            INS_EXTEST:
            begin
                sel_chain = 1'b1;
                test_mode = 1'b1;
            end
            INS_SAMPLE: sel_chain = 1'b1;
            INS_IDCODE: sel_chain = 1'b0;
            INS_FLOAT:
            begin
                sel_byp = 1'b1;
                float_all = 1'b1;
            end
            INS_FIXED:
            begin
                sel_byp = 1'b1;
                test_mode = 1'b1;
            end
            INS_BYPASS: sel_byp = 1'b1;
            default: sel_byp = 1'b1;
        endcase
    end

    assign cap_dr = rise && (state == ST_CAP_DR);
    assign sh_dr = rise && (state == ST_SHIFT_DR);
    assign upd_dr = rise && (state == ST_UPD_DR);

    // identification and bypass data registers
    always_ff @(posedge clk or posedge rst_any)
    begin
        if (rst_any)
        begin
            id_sh <= '0;
            byp <= 1'b0;
        end
        else
        begin
            if (cap_dr && !sel_chain && !sel_byp)
                id_sh <= {ID_VERSION, ID_PART, ID_MFR, ID_BIT0};
            else if (sh_dr && !sel_chain && !sel_byp)
                id_sh <= {tdi_s[1], id_sh[ID_W-1:1]};
            if (cap_dr && sel_byp)
                byp <= 1'b0;
            else if (sh_dr && sel_byp)
                byp <= tdi_s[1];
        end
    end

    // chain order from tdi: output cells, then input cells
    assign chain[0] = tdi_s[1];
    assign cell_sys = {pin_in, sys_out};

    genvar g;
    generate
        for (g = 0; g < 2*NPINS; g++)
        begin : g_cell
            bstap_cell u_cell (
                .clk(clk),
                .rst(rst_any),
                .capture(cap_dr && sel_chain),
                .shift(sh_dr && sel_chain),
                .update(upd_dr && sel_chain),
                .test_mode(test_mode),
                .scan_in(chain[g]),
                .sys_in(cell_sys[g]),
                .scan_out(chain[g+1]),
                .cell_out(cell_par[g])
            );
        end
    endgenerate

    // output enables in test mode: sys_oe ORed with a mask set all on by any chain update
    always_ff @(posedge clk or posedge rst_any)
    begin
        if (rst_any)
            oe_upd <= '0;
        else if (upd_dr && sel_chain)
            oe_upd <= '1;
    end

    always_comb
    begin
        pin_out = cell_par[NPINS-1:0];
        core_in = cell_par[2*NPINS-1:NPINS];
        if (float_all)
            pin_oe = '0;
        else if (test_mode)
            pin_oe = oe_upd | sys_oe;
        else
            pin_oe = sys_oe;
    end

    always_comb
    begin
        if (state == ST_SHIFT_IR)
            dr_out = ir_sh[0];
        else if (sel_chain)
            dr_out = chain[2*NPINS];
        else if (sel_byp)
            dr_out = byp;
        else
            dr_out = id_sh[0];
    end

    assign tdo_next = dr_out;

    // tdo changes on the falling tck edge only
    always_ff @(posedge clk or posedge rst_any)
    begin
        if (rst_any)
        begin
            tdo <= 1'b0;
            tdo_oe <= 1'b0;
        end
        else if (fall)
        begin
            tdo <= tdo_next;
            tdo_oe <= (state == ST_SHIFT_DR) || (state == ST_SHIFT_IR);
        end
    end

    // sleep is deliberately unused so the port runs through it
    logic sleep_unused;
    assign sleep_unused = sleep;

endmodule : bstap_top
`default_nettype wire

// *** bstap_monitor.sv ***
/* checker for the test port output and the boundary pins of bstap_top.
   assumes every tck phase lasts several clk cycles. */
`timescale 1ns/10ps
`default_nettype none
module bstap_monitor
#(
    parameter int NPINS = 8
)
(
    // clock and resets
    input wire logic clk,
    input wire logic rst,
    input wire logic por,
    // test port
    input wire logic tck,
    input wire logic tdo,
    input wire logic tdo_oe,
    // boundary pins
    input wire logic [NPINS-1:0] sys_out,
    input wire logic [NPINS-1:0] sys_oe,
    input wire logic [NPINS-1:0] pin_out,
    input wire logic [NPINS-1:0] pin_oe,
    input wire logic [NPINS-1:0] pin_in,
    input wire logic [NPINS-1:0] core_in
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst || por);
    tdo_edge_a: assert property ($changed(tdo) |-> !tck) else $error("tdo moved in tck high");
    oe_edge_a: assert property ($changed(tdo_oe) |-> !tck) else $error("tdo_oe moved in tck high");
    tdo_hold_a: assert property ($rose(tck) |=> $stable(tdo) [*6]) else $error("tdo not held");
    pin_upd_a: assert property ($changed(pin_out) && $stable(sys_out) |-> tck) else $error("pin_out moved");
    oe_upd_a: assert property ($changed(pin_oe) && $stable(sys_oe) |-> tck) else $error("pin_oe moved");
    core_upd_a: assert property ($changed(core_in) && $stable(pin_in) |-> tck) else $error("core_in moved");
    rst_quiet_a: assert property ($fell(rst) |-> !tdo_oe && !tdo) else $error("tdo live at reset");
    por_quiet_a: assert property ($fell(por) |-> !tdo_oe && !tdo) else $error("tdo live at power-on");
    cover property ($rose(tdo_oe));
    cover property ($fell(|pin_oe));
    cover property ($changed(pin_out) && $stable(sys_out));
endmodule : bstap_monitor
bind bstap_top bstap_monitor #(.NPINS(NPINS)) mon (.clk(clk), .rst(rst), .por(por), .tck(tck), .tdo(tdo),
    .tdo_oe(tdo_oe), .sys_out(sys_out), .sys_oe(sys_oe), .pin_out(pin_out), .pin_oe(pin_oe), .pin_in(pin_in),
    .core_in(core_in));
`default_nettype wire

// *** bstap_tester.sv ***
/* board tester model driving tck, tms and tdi.
   assumes clk at 200 MHz; tck runs 80 ns and stands low between calls. */
`timescale 1ns/10ps
`default_nettype none
module bstap_tester
(
    // clock
    input wire logic clk,
    // test port pins
    output logic tck,
    output logic tms,
    output logic tdi,
    input wire logic tdo,
    input wire logic tdo_oe
);
    initial
    begin
        tck = 1'b0;
        tms = 1'b1;
        tdi = 1'b1;
    end
    // one tck period; tdo read just before the rise
    task automatic step(input logic m, input logic d, output logic o);
        @(posedge clk);
        tms <= m;
        tdi <= d;
        repeat (4) @(posedge clk);
        o = tdo_oe ? tdo : 1'bz;
        tck <= 1'b1;
        repeat (8) @(posedge clk);
        tck <= 1'b0;
        repeat (3) @(posedge clk);
    endtask : step
    // idle to idle through one shift of n bits, lsb first
    task automatic scan(input logic ir, input int n, input logic [31:0] d, output logic [31:0] q);
        logic o;
        q = '0;
        step(1'b1, 1'b1, o);
        if (ir)
            step(1'b1, 1'b1, o);
        step(1'b0, 1'b1, o);
        step(1'b0, 1'b1, o);
        for (int i = 0; i < n; i++)
        begin
            step(i == n - 1, d[i], o);
            q[i] = o;
        end
        step(1'b1, 1'b1, o);
        step(1'b0, 1'b1, o);
    endtask : scan
endmodule : bstap_tester
`default_nettype wire

// *** bstap_tb.sv ***
/* self-checking bench for bstap_top with the tester model.
   assumes the design package and the checker are compiled first. */
`timescale 1ns/10ps
`default_nettype none
module tb
    import bstap_pkg::*;
;
    localparam logic [3:0] VER = 4'h3; // arbitrary value
    localparam logic [15:0] PART = 16'h1234; // arbitrary value
    localparam logic [10:0] MFR = 11'h2A5; // arbitrary value
    localparam logic [31:0] ID = {VER, PART, MFR, 1'b1};
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic por = 1'b0;
    logic sleep = 1'b0;
    logic tck, tms, tdi, tdo, tdo_oe, o;
    logic [7:0] sys_out = 8'h3C;
    logic [7:0] sys_oe = 8'hF0;
    logic [7:0] pin_in = 8'h96;
    logic [7:0] pin_out, pin_oe, core_in;
    logic [31:0] q;
    int fails = 0;
    int cmp_count = 0;
    always #2.5 clk = ~clk;
    bstap_top #(.NPINS(8), .ID_VERSION(VER), .ID_PART(PART), .ID_MFR(MFR)) dut (.clk(clk), .rst(rst), .por(por),
        .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo), .tdo_oe(tdo_oe), .sys_out(sys_out), .sys_oe(sys_oe),
        .pin_out(pin_out), .pin_oe(pin_oe), .pin_in(pin_in), .core_in(core_in), .sleep(sleep));
    bstap_tester tester (.clk(clk), .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo), .tdo_oe(tdo_oe));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            fails++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask : chk
    // tdi feeds the output cells first, so the last input cell leaves first
    function automatic logic [15:0] rev16(input logic [15:0] v);
        logic [15:0] r;
        for (int i = 0; i < 16; i++)
            r[i] = v[15 - i];
        return r;
    endfunction : rev16
    task automatic ld(input logic [3:0] c);
        tester.scan(1'b1, 4, {28'h0, c}, q);
    endtask : ld
    task automatic t_id;
        tester.scan(1'b0, 32, 32'h0, q);
        chk(q, ID);
        $display("test id done");
    endtask : t_id
    task automatic t_byp;
        ld(INS_BYPASS);
        chk(q[3:0], IR_CAPTURE);
        tester.scan(1'b0, 8, 32'hB5, q);
        chk(q[7:0], 8'h6A);
        $display("test bypass done");
    endtask : t_byp
    task automatic t_bound;
        sleep <= 1'b1;
        ld(INS_SAMPLE);
        tester.scan(1'b0, 16, 32'h5AC3, q);
        chk(q[15:0], rev16({pin_in, sys_out}));
        chk(pin_out, sys_out);
        ld(INS_EXTEST);
        chk({pin_oe, core_in, pin_out}, {8'hFF, rev16(16'h5AC3)});
        ld(INS_FIXED);
        chk({core_in, pin_out}, rev16(16'h5AC3));
        tester.scan(1'b0, 2, 32'h3, q);
        chk(q[1:0], 2'b10);
        ld(INS_FLOAT);
        chk(pin_oe, 8'h00);
        tester.scan(1'b0, 2, 32'h3, q);
        chk(q[1:0], 2'b10);
        ld(INS_BYPASS);
        chk({pin_oe, pin_out}, {sys_oe, sys_out});
        sys_out <= 8'h81;
        repeat (2) @(posedge clk);
        chk(pin_out, 8'h81);
        sleep <= 1'b0;
        $display("test boundary done");
    endtask : t_bound
    task automatic t_rst;
        for (int k = 0; k < 3; k++)
        begin
            ld(INS_BYPASS);
            if (k < 2)
            begin
                por <= (k == 0);
                rst <= (k == 1);
                @(posedge clk);
                por <= 1'b0;
                rst <= 1'b0;
            end
            else
                repeat (5) tester.step(1'b1, 1'b1, o);
            tester.step(1'b0, 1'b1, o);
            tester.scan(1'b0, 32, 32'h0, q);
            chk(q, ID);
        end
        $display("test reset done");
    endtask : t_rst
    task automatic test_done;
        $display("compares %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : test_done
    initial
    begin
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        tester.step(1'b0, 1'b1, o);
        t_id;
        t_byp;
        t_bound;
        t_rst;
        test_done;
    end
    // about 4700 cycles expected
    initial
    begin
        repeat (40000) @(posedge clk);
        fails++;
        $display("unexpected at %0t: watchdog", $time);
        test_done;
    end
endmodule : tb
`default_nettype wire
